// File: hw/spi_flash_register_access.sv
// Register-access command interpreter of the serial flash slave, sampled on the system clock.
`timescale 1ns/1ns
module spi_flash_register_access (
   input wire logic clk_sys, // System clock, 250 MHz
   input wire logic reset, // Synchronous reset, active high
   input wire logic cs_n_pin, // Chip select from host, active low
   input wire logic sck_pin, // Serial clock from host
   input wire logic si_pin, // Serial data in
   input wire logic wp_n_pin, // Write protect pin, active low
   input wire logic write_fail, // Register write failure report from the cell array
   input wire logic array_op_bulk, // Array request is a bulk erase
   input wire logic [5:0] array_op_part, // Top six address bits of an array request
   output logic so, // Serial data out
   output logic so_oe, // Serial out enable, high while driving
   output logic array_op_allowed, // Array request falls outside the protected block
   output logic extended_address_ctrl, // Bank register bit 7
   output logic [6:0] bank_bits // Address bits above A23 for three-byte addressing
);

   logic [2:0] sync_q [4];
   logic [3:0] pin_in;
   assign pin_in = {wp_n_pin, si_pin, sck_pin, cs_n_pin};

   genvar g;
   generate
      for (g = 0; g < 4; g++)
      begin : g_sync
         always_ff @(posedge clk_sys)
         begin
            if (reset)
               sync_q[g] <= {3{spi_reg_pkg::PIN_IDLE[g]}};
            else
               sync_q[g] <= {sync_q[g][1:0], pin_in[g]};
         end
      end
   endgenerate

   spi_reg_pkg::phase_t phase, next_phase;
   logic cs_f, sck_f, wp_f, next_cs_f, next_sck_f, next_wp_f;
   logic [2:0] bit_cnt, next_bit_cnt, out_idx, next_out_idx;
   logic [7:0] opcode_sr, next_opcode_sr, cmd, next_cmd;
   logic [15:0] data_sr, next_data_sr;
   logic [7:0] first_byte, next_first_byte, out_snap, next_out_snap;
   logic [4:0] data_cnt, next_data_cnt;
   logic next_so, next_so_oe, next_allowed;
   logic [7:0] sr1, next_sr1, cr, next_cr, bar, next_bar;
   logic [7:0] pend_sr, next_pend_sr, pend_cr, next_pend_cr;
   logic pend_both, next_pend_both, bank_armed, next_bank_armed;
   logic [spi_reg_pkg::TIMER_W-1:0] timer, next_timer;
   logic cs_rise, cs_fall, sck_rise, sck_fall, si_bit, hw_lock, write_in_progress, write_enable_latch;
   logic [7:0] rd_val, full_op;
   logic [6:0] prot_size;

   assign write_in_progress = sr1[spi_reg_pkg::SR_WIP_BIT];
   assign write_enable_latch = sr1[spi_reg_pkg::SR_WEL_BIT];
   assign extended_address_ctrl = bar[spi_reg_pkg::BAR_EXTENDED_ADDRESS_CTRL_BIT];
   assign bank_bits = bar[6:0];

   // A pin change counts once the second and third stages agree
   always_comb
   begin
      next_cs_f = (sync_q[0][1] == sync_q[0][2]) ? sync_q[0][2] : cs_f;
      next_sck_f = (sync_q[1][1] == sync_q[1][2]) ? sync_q[1][2] : sck_f;
      next_wp_f = (sync_q[3][1] == sync_q[3][2]) ? sync_q[3][2] : wp_f;
      cs_rise = ~cs_f & next_cs_f;
      cs_fall = cs_f & ~next_cs_f;
      sck_rise = ~cs_f & ~sck_f & next_sck_f;
      sck_fall = ~cs_f & sck_f & ~next_sck_f;
      si_bit = sync_q[2][2];
   end

   // quad mode frees the protect pin
   assign hw_lock = sr1[spi_reg_pkg::SR_STATUS_WRITE_DISABLE_BIT] & ~wp_f & ~cr[spi_reg_pkg::CR_QUAD_BIT];
   always_comb
   begin
      full_op = {opcode_sr[6:0], si_bit};
      // reads never wait for a write
      case (cmd)
         spi_reg_pkg::CONFIG_READ_CMD: rd_val = cr;
         spi_reg_pkg::BANK_READ_CMD: rd_val = bar;
         default: rd_val = sr1;
      endcase
      // protected block grows downward from the top of the array
      prot_size = 7'h01 << (sr1[spi_reg_pkg::SR_BP_LSB +: 3] - 3'h1);
      if (sr1[spi_reg_pkg::SR_BP_LSB +: 3] == 3'h0)
         next_allowed = 1'b1;
      else if (array_op_bulk)
         next_allowed = 1'b0;
      else
         next_allowed = {1'b0, array_op_part} < (7'h40 - prot_size);
   end

   always_comb
   begin
      next_phase = phase;
      next_bit_cnt = bit_cnt;
      next_opcode_sr = opcode_sr;
      next_cmd = cmd;
      next_data_sr = data_sr;
      next_first_byte = first_byte;
      next_data_cnt = data_cnt;
      next_out_idx = out_idx;
      next_out_snap = out_snap;
      next_so = so;
      next_so_oe = so_oe;
      next_sr1 = sr1;
      next_cr = cr;
      next_bar = bar;
      next_pend_sr = pend_sr;
      next_pend_cr = pend_cr;
      next_pend_both = pend_both;
      next_bank_armed = bank_armed;
      next_timer = timer;

      // self-timed completion clears busy and the latch
      if (write_in_progress)
      begin
         next_timer = timer - 1'b1;
         if (timer == 1)
         begin
            next_sr1 = (sr1 & ~spi_reg_pkg::SR_WRITE_MASK) | (pend_sr & spi_reg_pkg::SR_WRITE_MASK);
            next_sr1[spi_reg_pkg::SR_WIP_BIT] = 1'b0;
            next_sr1[spi_reg_pkg::SR_WEL_BIT] = 1'b0;
            // failure reported through the program error bit
            if (write_fail)
               next_sr1[spi_reg_pkg::SR_P_ERR_BIT] = 1'b1;
            if (pend_both)
               next_cr = pend_cr;
         end
      end

      if (cs_fall)
      begin
         next_phase = spi_reg_pkg::PH_CMD;
         next_bit_cnt = 3'h0;
         next_data_cnt = 5'h00;
      end

      // shift in on rising edges, MSB first
      if (sck_rise)
      begin
         case (phase)
            spi_reg_pkg::PH_CMD:
            begin
               next_opcode_sr = full_op;
               next_bit_cnt = bit_cnt + 3'h1;
               if (bit_cnt == 3'h7)
               begin
                  next_cmd = full_op;
                  next_out_idx = 3'h7;
                  case (full_op)
                     spi_reg_pkg::STATUS_ONE_READ_CMD,
                     spi_reg_pkg::CONFIG_READ_CMD,
                     spi_reg_pkg::BANK_READ_CMD: next_phase = spi_reg_pkg::PH_OUT;
                     spi_reg_pkg::BANK_WRITE_CMD,
                     spi_reg_pkg::BANK_ACCESS_CMD,
                     spi_reg_pkg::REGISTER_WRITE_CMD,
                     spi_reg_pkg::WRITE_ENABLE_CMD: next_phase = spi_reg_pkg::PH_DATA;
                     default: next_phase = spi_reg_pkg::PH_IGNORE;
                  endcase
               end
            end
            spi_reg_pkg::PH_DATA:
            begin
               next_data_sr = {data_sr[14:0], si_bit};
               if (data_cnt != spi_reg_pkg::DATA_CNT_SAT)
                  next_data_cnt = data_cnt + 5'h01;
               if (data_cnt == 5'h07)
                  next_first_byte = {data_sr[6:0], si_bit};
            end
            default: next_phase = phase;
         endcase
      end

      // per-byte snapshot repeats the register each eight clocks
      if (sck_fall && phase == spi_reg_pkg::PH_OUT)
      begin
         next_so_oe = 1'b1;
         next_out_idx = out_idx - 3'h1;
         if (out_idx == 3'h7)
         begin
            next_out_snap = rd_val;
            next_so = rd_val[7];
         end
         else
            next_so = out_snap[out_idx];
      end

      if (cs_rise)
      begin
         next_phase = spi_reg_pkg::PH_CMD;
         next_so_oe = 1'b0;
         next_bit_cnt = 3'h0;
         next_data_cnt = 5'h00;
         // any completed frame closes bank access unless it is B9h itself
         next_bank_armed = (phase == spi_reg_pkg::PH_DATA) &&
            (cmd == spi_reg_pkg::BANK_ACCESS_CMD) && (data_cnt == 5'h00);
         if (phase == spi_reg_pkg::PH_DATA)
         begin
            case (cmd)
               spi_reg_pkg::WRITE_ENABLE_CMD:
               begin
                  // latch set; wins over a completion clear in the same cycle
                  if (data_cnt == 5'h00)
                     next_sr1[spi_reg_pkg::SR_WEL_BIT] = 1'b1;
               end
               spi_reg_pkg::BANK_WRITE_CMD:
               begin
                  if (data_cnt >= spi_reg_pkg::DATA_ONE_BYTE)
                     next_bar = first_byte;
               end
               spi_reg_pkg::REGISTER_WRITE_CMD:
               begin
                  if (bank_armed)
                  begin
                     // only the two low bank bits, bit 7 kept
                     if (data_cnt >= spi_reg_pkg::DATA_ONE_BYTE)
                        next_bar[1:0] = first_byte[1:0];
                  end
                  // latch, exact count and protection gate the write
                  else if (write_enable_latch && !write_in_progress && !hw_lock &&
                     (data_cnt == spi_reg_pkg::DATA_ONE_BYTE ||
                     data_cnt == spi_reg_pkg::DATA_TWO_BYTES))
                  begin
                     next_sr1[spi_reg_pkg::SR_WIP_BIT] = 1'b1;
                     next_timer = spi_reg_pkg::REG_WRITE_CYCLES;
                     next_pend_sr = first_byte;
                     next_pend_cr = data_sr[7:0];
                     next_pend_both = (data_cnt == spi_reg_pkg::DATA_TWO_BYTES);
                  end
               end
               default: next_phase = spi_reg_pkg::PH_CMD;
            endcase
         end
      end
   end

   always_ff @(posedge clk_sys)
   begin
      if (reset)
      begin
         cs_f <= 1'b1;
         sck_f <= 1'b0;
         wp_f <= 1'b1;
         phase <= spi_reg_pkg::PH_CMD;
         bit_cnt <= 3'h0;
         opcode_sr <= 8'h00;
         cmd <= 8'h00;
         data_sr <= 16'h0000;
         first_byte <= 8'h00;
         data_cnt <= 5'h00;
         out_idx <= 3'h7;
         out_snap <= 8'h00;
         so <= 1'b0;
         so_oe <= 1'b0;
         sr1 <= spi_reg_pkg::SR_RESET;
         cr <= spi_reg_pkg::CR_RESET;
         bar <= spi_reg_pkg::BAR_RESET;
         pend_sr <= 8'h00;
         pend_cr <= 8'h00;
         pend_both <= 1'b0;
         bank_armed <= 1'b0;
         timer <= '0;
         array_op_allowed <= 1'b0;
      end
      else
      begin
         cs_f <= next_cs_f;
         sck_f <= next_sck_f;
         wp_f <= next_wp_f;
         phase <= next_phase;
         bit_cnt <= next_bit_cnt;
         opcode_sr <= next_opcode_sr;
         cmd <= next_cmd;
         data_sr <= next_data_sr;
         first_byte <= next_first_byte;
         data_cnt <= next_data_cnt;
         out_idx <= next_out_idx;
         out_snap <= next_out_snap;
         so <= next_so;
         so_oe <= next_so_oe;
         sr1 <= next_sr1;
         cr <= next_cr;
         bar <= next_bar;
         pend_sr <= next_pend_sr;
         pend_cr <= next_pend_cr;
         pend_both <= next_pend_both;
         bank_armed <= next_bank_armed;
         timer <= next_timer;
         array_op_allowed <= next_allowed;
      end
   end

   logic exec_data;
   assign exec_data = cs_rise && phase == spi_reg_pkg::PH_DATA;
   a_wel_set: assert property (@(posedge clk_sys) disable iff (reset)
      exec_data && cmd == spi_reg_pkg::WRITE_ENABLE_CMD && data_cnt == 5'h00 |=> write_enable_latch)
      else $error("write enable did not set the latch");

   a_bar_load: assert property (@(posedge clk_sys) disable iff (reset)
      exec_data && cmd == spi_reg_pkg::BANK_WRITE_CMD && data_cnt >= 5'h08
      |=> bar == $past(first_byte))
      else $error("bank write did not load the byte");

   a_bar_status: assert property (@(posedge clk_sys) disable iff (reset)
      exec_data && cmd == spi_reg_pkg::BANK_WRITE_CMD && !write_in_progress |=> !write_in_progress && $stable(sr1[6:5]))
      else $error("bank write disturbed status");

   a_access_keep: assert property (@(posedge clk_sys) disable iff (reset)
      exec_data && bank_armed && cmd == spi_reg_pkg::REGISTER_WRITE_CMD
      |=> $stable(bar[7:2]) && !bank_armed && !write_in_progress)
      else $error("bank access write touched more than two bits");

   a_access_close: assert property (@(posedge clk_sys) disable iff (reset)
      cs_rise && cmd != spi_reg_pkg::BANK_ACCESS_CMD |=> !bank_armed)
      else $error("bank access stayed open");

   a_wrr_count: assert property (@(posedge clk_sys) disable iff (reset)
      exec_data && !bank_armed && !write_in_progress && cmd == spi_reg_pkg::REGISTER_WRITE_CMD &&
      data_cnt != 5'h08 && data_cnt != 5'h10 |=> !write_in_progress)
      else $error("odd length register write started");

   a_hw_lock: assert property (@(posedge clk_sys) disable iff (reset)
      exec_data && !bank_armed && !write_in_progress && hw_lock |=> !write_in_progress)
      else $error("locked register write started");

   a_wel_needed: assert property (@(posedge clk_sys) disable iff (reset)
      $rose(write_in_progress) |-> $past(write_enable_latch))
      else $error("register write without the latch");

   a_wip_end: assert property (@(posedge clk_sys) disable iff (reset)
      $rose(write_in_progress) |-> write_in_progress[*8] ##0 (timer == spi_reg_pkg::REG_WRITE_CYCLES - 10'd7))
      else $error("busy bit dropped early");

   a_wel_clear: assert property (@(posedge clk_sys) disable iff (reset)
      $fell(write_in_progress) && !$past(cs_rise) |-> !write_enable_latch)
      else $error("latch not cleared at completion");
endmodule

// File: hw/spi_reg_pkg.sv
// Opcodes, register fields, reset values and timing for the register-access command logic.
// Contract
// - Opcode 35h streams the configuration register, repeating per eight clocks.
// - Configuration reads work anytime, even during a running write, showing live contents.
// - Opcode 16h streams the eight-bit bank register, repeating per eight clocks.
// - Opcode 17h plus one byte loads the bank register without write enable.
// - Bank bit 7 off means three-byte addresses take high bits from bank bits.
// - Direct bank write leaves error and busy status bits untouched.
// - After B9h, next register write loads only bank bits 1:0, no enable.
// - That write closes bank access; bank bit 7 keeps its value.
// - Any other command or chip-select cycle after B9h closes bank access.
// - Register write (01h) needs the write-enable latch set beforehand.
// - Exactly 8 data bits write status; 16 write both; else cancelled.
// - Write starts at chip-select rise; busy until done, then latch cleared.
// - A failed register write sets the program error bit, status bit 6.
// - Write-disable bit clear: writes allowed with latch set, any protect pin.
// - Write-disable set, protect pin low, quad bit clear: every status and configuration write refused.
// - Hardware lock ends only with protect pin high; quad mode disables it.
// - Block-protected memory refuses program and erase; the rest accepts them.
// - Opcode 06h sets the write-enable latch, status bit 1.
// - Opcode 05h streams status register one, refreshed per eight clocks.
package spi_reg_pkg;

   localparam logic [7:0] STATUS_ONE_READ_CMD = 8'h05;
   localparam logic [7:0] CONFIG_READ_CMD = 8'h35;
   localparam logic [7:0] BANK_READ_CMD = 8'h16;
   localparam logic [7:0] BANK_WRITE_CMD = 8'h17;
   localparam logic [7:0] BANK_ACCESS_CMD = 8'hb9;
   localparam logic [7:0] REGISTER_WRITE_CMD = 8'h01;
   localparam logic [7:0] WRITE_ENABLE_CMD = 8'h06;

   localparam int SR_WIP_BIT = 0;
   localparam int SR_WEL_BIT = 1;
   localparam int SR_BP_LSB = 2;
   localparam int SR_E_ERR_BIT = 5;
   localparam int SR_P_ERR_BIT = 6;
   localparam int SR_STATUS_WRITE_DISABLE_BIT = 7;
   localparam int CR_QUAD_BIT = 1;
   localparam int BAR_EXTENDED_ADDRESS_CTRL_BIT = 7;

   // Bits a register write may change in status register one
   localparam logic [7:0] SR_WRITE_MASK = 8'h9c;
   localparam logic [7:0] SR_RESET = 8'h00;
   localparam logic [7:0] CR_RESET = 8'h00;
   localparam logic [7:0] BAR_RESET = 8'h00;

   localparam int CLK_PERIOD_NS = 4;
   localparam int REG_WRITE_TIME_NS = 2000;
   localparam int TIMER_W = 10;
   localparam logic [TIMER_W-1:0] REG_WRITE_CYCLES =
      TIMER_W'(REG_WRITE_TIME_NS / CLK_PERIOD_NS);

   localparam logic [4:0] DATA_CNT_SAT = 5'h11;
   localparam logic [4:0] DATA_ONE_BYTE = 5'h08;
   localparam logic [4:0] DATA_TWO_BYTES = 5'h10;

   // Idle level of cs_n, sck, si, wp_n, index order 0..3
   localparam logic [3:0] PIN_IDLE = 4'h9;

   typedef enum logic [1:0] {
      PH_CMD = 2'b00,
      PH_DATA = 2'b01,
      PH_OUT = 2'b11,
      PH_IGNORE = 2'b10
   } phase_t;

endpackage

// File: verification/spi_host_model.sv
// Host side model of the serial link: mode 0 frames, sampling the reply
`timescale 1ns/1ns
module spi_host_model (
   input wire logic clk_sys, // Bench system clock
   output logic cs_n, // Chip select, active low
   output logic sck, // Serial clock, stands low between frames
   output logic si, // Serial data to the device
   input wire logic so // Serial data from the device
);
   initial
   begin
      cs_n = 1'b1;
      sck = 1'b0;
      si = 1'b0;
   end

   // Outside a frame the data line holds no value, so it toggles every cycle
   always @(posedge clk_sys)
   begin
      if (cs_n)
         si <= ~si;
   end

   // Sends an opcode and nbits of wdata, returning the last 16 bits seen on so
   task automatic xfer(input logic [7:0] op, input logic [15:0] wdata, input int nbits,
                       output logic [15:0] rdata);
      logic [23:0] sh;
      sh = {op, wdata};
      rdata = 16'h0000;
      @(posedge clk_sys);
      cs_n <= 1'b0;
      repeat (4) @(posedge clk_sys);
      for (int i = 0; i < 8 + nbits; i++)
      begin
         si <= sh[23];
         sck <= 1'b0;
         sh = sh << 1;
         repeat (4) @(posedge clk_sys);
         sck <= 1'b1;
         repeat (4) @(posedge clk_sys);
         rdata = {rdata[14:0], so};
      end
      sck <= 1'b0;
      repeat (4) @(posedge clk_sys);
      cs_n <= 1'b1;
      repeat (12) @(posedge clk_sys);
   endtask
endmodule

// File: verification/test_spi_flash_register_access.sv
// Self-checking bench for the register-access command logic
`timescale 1ns/1ns
module test_spi_flash_register_access;
   logic clk_sys = 1'b0;
   logic reset = 1'b1;
   logic wp_n_pin = 1'b1;
   logic write_fail = 1'b0;
   logic array_op_bulk = 1'b0;
   logic [5:0] array_op_part = 6'h00;
   logic cs_n, sck, si, so, so_oe, array_op_allowed, extended_address_ctrl;
   logic [6:0] bank_bits;
   logic [15:0] rd;
   logic [7:0] bank;
   int failures = 0;
   int cmp_count = 0;
   int oe_rises = 0;
   logic oe_q = 1'b0;

   always #2 clk_sys = ~clk_sys;

   // Counts how often the device starts driving its serial output
   always @(posedge clk_sys)
   begin
      oe_q <= so_oe;
      if (so_oe && !oe_q)
         oe_rises <= oe_rises + 1;
   end

   spi_host_model u_host (.clk_sys(clk_sys), .cs_n(cs_n), .sck(sck), .si(si), .so(so));

   spi_flash_register_access u_dut (
      .clk_sys(clk_sys), .reset(reset), .cs_n_pin(cs_n), .sck_pin(sck), .si_pin(si),
      .wp_n_pin(wp_n_pin), .write_fail(write_fail), .array_op_bulk(array_op_bulk),
      .array_op_part(array_op_part), .so(so), .so_oe(so_oe),
      .array_op_allowed(array_op_allowed), .extended_address_ctrl(extended_address_ctrl),
      .bank_bits(bank_bits));

   task automatic check(input logic [7:0] got, input logic [7:0] exp);
      cmp_count++;
      if (got !== exp)
      begin
         failures++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic finish_test();
      $display("compares %0d, mismatches %0d", cmp_count, failures);
      if (failures == 0 && cmp_count > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask

   task automatic test_end(input string name);
      $display("done: %s", name);
   endtask

   task automatic cmd(input logic [7:0] op, input logic [15:0] data, input int nbits);
      u_host.xfer(op, data, nbits, rd);
   endtask

   // Two repeated bytes are read, both must match
   task automatic rdreg(input logic [7:0] op, input logic [7:0] exp);
      int n;
      n = oe_rises;
      u_host.xfer(op, 16'h0000, 16, rd);
      check(rd[15:8], exp);
      check(rd[7:0], exp);
      check(8'(oe_rises - n), 8'h01);
      check({7'h00, so_oe}, 8'h00);
   endtask

   task automatic register_write_cmd(input logic [15:0] data, input int nbits);
      cmd(spi_reg_pkg::WRITE_ENABLE_CMD, 16'h0000, 0);
      cmd(spi_reg_pkg::REGISTER_WRITE_CMD, data, nbits);
      repeat (520) @(posedge clk_sys);
   endtask

   function automatic logic exp_allowed(input logic [2:0] bp, input logic [5:0] part,
                                        input logic bulk);
      if (bp == 3'h0)
         return 1'b1;
      if (bulk)
         return 1'b0;
      // The top 2^(bp-1) of the 64 parts are protected
      return (int'(part) + (1 << (int'(bp) - 1))) <= 63;
   endfunction

   initial
   begin
      void'($urandom(32'hf598));
      repeat (4) @(posedge clk_sys);
      reset <= 1'b0;
      repeat (8) @(posedge clk_sys);
      rdreg(spi_reg_pkg::STATUS_ONE_READ_CMD, 8'h00);
      rdreg(spi_reg_pkg::CONFIG_READ_CMD, 8'h00);
      rdreg(spi_reg_pkg::BANK_READ_CMD, 8'h00);
      test_end("reset values");
      bank = (8'($urandom) & 8'h07) | 8'h80;
      cmd(spi_reg_pkg::BANK_WRITE_CMD, {bank, 8'h00}, 8);
      rdreg(spi_reg_pkg::BANK_READ_CMD, bank);
      check({7'h00, extended_address_ctrl}, {7'h00, bank[7]});
      check({1'b0, bank_bits}, {1'b0, bank[6:0]});
      rdreg(spi_reg_pkg::STATUS_ONE_READ_CMD, 8'h00);
      test_end("bank write");
      cmd(spi_reg_pkg::REGISTER_WRITE_CMD, 16'h1c00, 8);
      rdreg(spi_reg_pkg::STATUS_ONE_READ_CMD, 8'h00);
      cmd(spi_reg_pkg::WRITE_ENABLE_CMD, 16'h0000, 0);
      rdreg(spi_reg_pkg::STATUS_ONE_READ_CMD, 8'h02);
      cmd(spi_reg_pkg::REGISTER_WRITE_CMD, 16'h0c00, 8);
      cmd(spi_reg_pkg::BANK_WRITE_CMD, {bank, 8'h00}, 8);
      rdreg(spi_reg_pkg::STATUS_ONE_READ_CMD, 8'h03);
      rdreg(spi_reg_pkg::CONFIG_READ_CMD, 8'h00);
      repeat (520) @(posedge clk_sys);
      rdreg(spi_reg_pkg::STATUS_ONE_READ_CMD, 8'h0c);
      cmd(spi_reg_pkg::WRITE_ENABLE_CMD, 16'h0000, 0);
      cmd(spi_reg_pkg::REGISTER_WRITE_CMD, 16'h0000, 12);
      rdreg(spi_reg_pkg::STATUS_ONE_READ_CMD, 8'h0e);
      test_end("register write");
      for (int b = 0; b < 8; b++)
      begin
         register_write_cmd({3'h0, 3'(b), 2'h0, 8'h00}, 16);
         rdreg(spi_reg_pkg::STATUS_ONE_READ_CMD, {3'h0, 3'(b), 2'h0});
         for (int k = 0; k < 4; k++)
         begin
            array_op_part <= (k == 0) ? 6'h3f : 6'($urandom);
            array_op_bulk <= (k == 1) ? 1'b1 : 1'b0;
            repeat (2) @(posedge clk_sys);
            check({7'h00, array_op_allowed},
                  {7'h00, exp_allowed(3'(b), array_op_part, array_op_bulk)});
         end
      end
      test_end("block protect");
      register_write_cmd(16'h8000, 8);
      wp_n_pin <= 1'b0;
      register_write_cmd(16'h8400, 8);
      u_host.xfer(spi_reg_pkg::STATUS_ONE_READ_CMD, 16'h0000, 16, rd);
      check(rd[7:0] & 8'hfd, 8'h80);
      wp_n_pin <= 1'b1;
      register_write_cmd(16'h8402, 16);
      rdreg(spi_reg_pkg::CONFIG_READ_CMD, 8'h02);
      wp_n_pin <= 1'b0;
      register_write_cmd(16'h0002, 16);
      rdreg(spi_reg_pkg::STATUS_ONE_READ_CMD, 8'h00);
      register_write_cmd(16'h0000, 16);
      rdreg(spi_reg_pkg::CONFIG_READ_CMD, 8'h00);
      wp_n_pin <= 1'b1;
      test_end("write lock");
      cmd(spi_reg_pkg::BANK_ACCESS_CMD, 16'h0000, 0);
      cmd(spi_reg_pkg::REGISTER_WRITE_CMD, 16'hfe00, 8);
      bank = {bank[7:2], 2'b10};
      rdreg(spi_reg_pkg::BANK_READ_CMD, bank);
      check({7'h00, extended_address_ctrl}, 8'h01);
      cmd(spi_reg_pkg::BANK_ACCESS_CMD, 16'h0000, 0);
      rdreg(spi_reg_pkg::STATUS_ONE_READ_CMD, 8'h00);
      cmd(spi_reg_pkg::REGISTER_WRITE_CMD, 16'h0100, 8);
      rdreg(spi_reg_pkg::BANK_READ_CMD, bank);
      cmd(spi_reg_pkg::BANK_ACCESS_CMD, 16'h0000, 0);
      cmd(8'h00, 16'h0000, 8);
      cmd(spi_reg_pkg::REGISTER_WRITE_CMD, 16'h0300, 8);
      rdreg(spi_reg_pkg::BANK_READ_CMD, bank);
      test_end("bank access");
      write_fail <= 1'b1;
      register_write_cmd(16'h0000, 8);
      write_fail <= 1'b0;
      rdreg(spi_reg_pkg::STATUS_ONE_READ_CMD, 8'h40);
      cmd(spi_reg_pkg::BANK_WRITE_CMD, {bank, 8'h00}, 8);
      rdreg(spi_reg_pkg::STATUS_ONE_READ_CMD, 8'h40);
      test_end("write failure");
      finish_test();
   end

   // The tests need about 20000 cycles
   initial
   begin
      repeat (60000) @(posedge clk_sys);
      failures++;
      finish_test();
   end
endmodule
